// ### pbcs_regs.sv
// Purpose: Indirect management bank with basic control and status.
// Assumes: MAC access logic presents one request per cycle, same clock.
// Notes:   Only control, status and the two identifier words are implemented;
//          other mapped indexes read zero here and ignore writes.
module pbcs_regs #(
   parameter logic [15:0] ID_HIGH_VALUE = 16'h1234,  // Arbitrary value.
   parameter logic [15:0] ID_LOW_VALUE  = 16'h5678,  // Arbitrary value.
   parameter int          SRST_CYCLES   = pbcs_pkg::SOFT_RESET_CYCLES
) (
   input  wire logic                        clk_i,         // Clock.
   input  wire logic                        rst_i,         // Reset, high.
   // Indirect access path from the MAC.
   input  wire logic                        acc_req_i,     // Request.
   input  wire logic                        acc_write_i,   // 1 write.
   input  wire logic [pbcs_pkg::IDX_W-1:0]  acc_index_i,   // Index.
   input  wire logic [pbcs_pkg::DATA_W-1:0] acc_wdata_i,   // Write data.
   output logic                             acc_ready_o,   // Accepting.
   output logic                             acc_done_o,    // Answer.
   output logic                             acc_err_o,     // Bad index.
   output logic [pbcs_pkg::DATA_W-1:0]      acc_rdata_o,   // Read data.
   // Strap pin.
   input  wire logic                        speed_strap_i, // Strap pin.
   // PHY core status.
   input  wire logic                        an_complete_i, // AN done.
   input  wire logic                        remote_fault_i,// Fault seen.
   input  wire logic                        link_up_i,     // Link live.
   input  wire logic                        jabber_i,      // Jabber seen.
   input  wire logic                        an_speed_100_i,// AN speed.
   input  wire logic                        an_full_dup_i, // AN duplex.
   // PHY core control.
   output logic                             soft_reset_o,  // Core reset.
   output logic                             loopback_o,    // Loopback.
   output logic                             speed_100_o,   // Speed.
   output logic                             full_duplex_o, // Duplex.
   output logic                             an_enable_o,   // AN on.
   output logic                             an_restart_o,  // AN pulse.
   output logic                             power_down_o,  // Power-down.
   output logic                             col_test_o     // COL test.
);
   import pbcs_pkg::*;

   // ==========================================================
   // Strap synchroniser.
   logic strap_meta;                      // First stage, read by second only.
   logic strap_sync;                      // Second stage.

   // The strap is a pin and may move at any time relative to the clock.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         strap_meta <= 1'b0;
         strap_sync <= 1'b0;
      end else begin
         strap_meta <= speed_strap_i;
         strap_sync <= strap_meta;
      end
   end

   // ==========================================================
   // Sequencer and counter.
   localparam int CNT_W = 16;             // Counter width.
   localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(STRAP_SYNC_CYCLES - 1);
   localparam logic [CNT_W-1:0] SRST_LAST = CNT_W'(SRST_CYCLES - 1);

   pbcs_state_t      state;               // Current state.
   pbcs_state_t      next_state;          // Next state.
   logic [CNT_W-1:0] count;               // Cycle counter.
   logic [CNT_W-1:0] next_count;          // Next counter value.

   // Access decode.
   logic acc_take;                        // Request accepted.
   logic acc_wr;                          // Accepted write.
   logic acc_rd;                          // Accepted read.
   logic idx_ok;                          // Index is mapped.
   logic sel_ctl;                         // Control selected.
   logic sel_sts;                         // Status selected.
   logic ctl_write;                       // Write lands in control.
   logic srst_start;                      // Soft reset begins.
   logic srst_end;                        // Soft reset last cycle.
   logic init_end;                        // Strap load cycle.

   assign acc_ready_o = (state != PBCS_INIT);
   assign acc_take    = acc_req_i && acc_ready_o;
   assign acc_wr      = acc_take && acc_write_i;
   assign acc_rd      = acc_take && !acc_write_i;
   assign idx_ok      = pbcs_index_valid(acc_index_i);
   assign sel_ctl     = (acc_index_i == IDX_CONTROL);
   assign sel_sts     = (acc_index_i == IDX_STATUS);
   // Writes are dropped while a soft reset runs, since the register is
   // about to be restored anyway and a half-applied write would be lost.
   assign ctl_write   = acc_wr && sel_ctl && (state == PBCS_RUN);
   assign srst_start  = ctl_write && acc_wdata_i[CTL_SOFT_RESET];
   assign srst_end    = (state == PBCS_SRST) && (count == SRST_LAST);
   assign init_end    = (state == PBCS_INIT) && (count == INIT_LAST);

   // Next-state selection for the sequencer.
   always_comb begin
      next_state = state;
      next_count = count;
      case (state)
         PBCS_INIT: begin
            next_count = count + CNT_W'(1);
            if (init_end) begin
               next_state = PBCS_RUN;
               next_count = '0;
            end
         end
         PBCS_RUN: begin
            next_count = '0;
            if (srst_start) begin
               next_state = PBCS_SRST;
            end
         end
         PBCS_SRST: begin
            next_count = count + CNT_W'(1);
            if (srst_end) begin
               next_state = PBCS_RUN;
               next_count = '0;
            end
         end
         default: begin
            next_state = PBCS_INIT;
            next_count = '0;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state <= PBCS_INIT;
         count <= '0;
      end else begin
         state <= next_state;
         count <= next_count;
      end
   end

   // ==========================================================
   // Basic control register.
   logic [15:0] ctl;                      // Stored control bits.
   logic [15:0] ctl_default;              // Default with strap bits.
   logic [15:0] next_ctl;                 // Next control value.
   logic        restart;                  // Restart pulse register.

   // Speed and autonegotiation defaults follow the strap level.
   always_comb begin
      ctl_default                = CTL_RESET_VALUE;
      ctl_default[CTL_SPEED_100] = strap_sync;
      ctl_default[CTL_AN_ENABLE] = strap_sync;
   end

   // No basic control field is kept across soft reset, so the whole
   // register is restored; kept fields elsewhere would skip this path.
   assign next_ctl = (init_end || srst_end) ? ctl_default :
                     ctl_write ? (acc_wdata_i & CTL_WRITE_MASK) : ctl;

   // Control storage; the two self-clearing bits are never stored.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         ctl <= CTL_RESET_VALUE;
      end else begin
         ctl <= next_ctl;
      end
   end

   // Restart is a one-cycle pulse, so the bit reads back as zero.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         restart <= 1'b0;
      end else begin
         restart <= ctl_write && acc_wdata_i[CTL_AN_RESTART];
      end
   end

   // ==========================================================
   // Control outputs to the PHY core.
   logic an_on;                           // Autonegotiation enabled.

   assign an_on         = ctl[CTL_AN_ENABLE];
   assign soft_reset_o  = (state == PBCS_SRST);
   assign loopback_o    = ctl[CTL_LOOPBACK];
   assign an_enable_o   = an_on;
   assign an_restart_o  = restart && an_on;
   assign power_down_o  = ctl[CTL_POWER_DOWN];
   assign col_test_o    = ctl[CTL_COL_TEST];
   // Manual speed and duplex only count with negotiation off.
   assign speed_100_o   = an_on ? an_speed_100_i
                                : ctl[CTL_SPEED_100];
   assign full_duplex_o = an_on ? an_full_dup_i
                                : ctl[CTL_DUPLEX];

   // ==========================================================
   // Latching status bits.
   logic sts_read;                        // Status register read.
   logic fault_held;                      // Remote fault latch.
   logic link_held;                       // Link latch.
   logic jabber_held;                     // Jabber latch.
   logic an_done;                         // Live completion.

   assign sts_read = acc_rd && sel_sts;
   // Completion is meaningless while powered down or in soft reset.
   assign an_done  = an_complete_i && !ctl[CTL_POWER_DOWN] &&
                     (state == PBCS_RUN);

   pbcs_latch #(.LATCH_HIGH(1'b1)) u_fault (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (soft_reset_o),
      .live_i  (remote_fault_i),
      .read_i  (sts_read),
      .held_o  (fault_held)
   );

   pbcs_latch #(.LATCH_HIGH(1'b0)) u_link (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (soft_reset_o),
      .live_i  (link_up_i),
      .read_i  (sts_read),
      .held_o  (link_held)
   );

   pbcs_latch #(.LATCH_HIGH(1'b1)) u_jabber (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .clear_i (soft_reset_o),
      .live_i  (jabber_i),
      .read_i  (sts_read),
      .held_o  (jabber_held)
   );

   // ==========================================================
   // Read data selection.
   logic [15:0] sts_value;                // Assembled status word.
   logic [15:0] ctl_value;                // Control as read back.
   logic [15:0] rd_mux;                   // Selected read word.

   // Fixed bits come from one constant; reserved bits stay zero.
   always_comb begin
      sts_value                   = STS_FIXED_VALUE;
      sts_value[STS_AN_COMPLETE]  = an_done;
      sts_value[STS_REMOTE_FAULT] = fault_held;
      sts_value[STS_AN_ABILITY]   = 1'b1;
      sts_value[STS_LINK_UP]      = link_held;
      sts_value[STS_JABBER]       = jabber_held;
      sts_value[STS_EXT_CAPS]     = 1'b1;
   end

   // Reset bit reads one while the core reset is still running.
   always_comb begin
      ctl_value                 = ctl;
      ctl_value[CTL_SOFT_RESET] = soft_reset_o;
   end

   assign rd_mux = (acc_index_i == IDX_CONTROL) ? ctl_value :
                   (acc_index_i == IDX_STATUS)  ? sts_value :
                   (acc_index_i == IDX_ID_HIGH) ? ID_HIGH_VALUE :
                   (acc_index_i == IDX_ID_LOW)  ? ID_LOW_VALUE :
                   16'h0000;

   // ==========================================================
   // Answer registers.
   // Every accepted request answers one cycle later; read data is held
   // until the next read so the MAC may copy it at leisure.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         acc_done_o  <= 1'b0;
         acc_err_o   <= 1'b0;
         acc_rdata_o <= 16'h0000;
      end else begin
         acc_done_o <= acc_take;
         acc_err_o  <= acc_take && !idx_ok;
         if (acc_rd) begin
            acc_rdata_o <= idx_ok ? rd_mux : 16'h0000;
         end
      end
   end

endmodule : pbcs_regs

// ### pbcs_pkg.sv
// Purpose: Shared constants for the PHY basic control and status bank.
// Assumes: 100 MHz system clock, 16-bit management registers, 5-bit index.
// Notes:   Indexes are decimal register numbers, not byte addresses.
//
// How it works
// - Access only through indirect access and data path.
// - Decimal index selects one of thirteen registers.
// - Kept fields survive only the control soft reset.
// - Control bit 15 starts soft reset, self-clears.
// - Control bit 14 selects loopback mode.
// - Speed and duplex bits ignored under autonegotiation.
// - Control bit 12 enables autonegotiation, overriding both.
// - Bit 11 powers down; completion shows status bit 5; here bit 5 reads zero while powered down.
// - Control bit 9 restarts autonegotiation, self-clears.
// - Control bit 7 enables the collision test.
// - Speed and autonegotiation defaults come from strap.
// - Status bits 15..11 report fixed abilities.
// - Status bit 5 shows autonegotiation complete.
// - Status bit 4 latches remote fault high.
// - Status bit 3 always reads one.
// - Status bit 2 latches link loss low.
// - Status bit 1 latches jabber high.
// - Status bit 0 always reads one.
package pbcs_pkg;

   // ==========================================================
   // Widths.
   localparam int IDX_W  = 5;             // Index width.
   localparam int DATA_W = 16;            // Register width.

   // ==========================================================
   // Register indexes.
   localparam logic [4:0] IDX_CONTROL    = 5'h00;  // Basic control.
   localparam logic [4:0] IDX_STATUS     = 5'h01;  // Basic status.
   localparam logic [4:0] IDX_ID_HIGH    = 5'h02;  // Identifier high.
   localparam logic [4:0] IDX_ID_LOW     = 5'h03;  // Identifier low.
   localparam logic [4:0] IDX_AN_ADV     = 5'h04;  // Advertisement.
   localparam logic [4:0] IDX_AN_PARTNER = 5'h05;  // Partner ability.
   localparam logic [4:0] IDX_AN_EXP     = 5'h06;  // Expansion.
   localparam logic [4:0] IDX_MODE       = 5'h11;  // Mode control/status.
   localparam logic [4:0] IDX_SPEC_MODES = 5'h12;  // Special modes.
   localparam logic [4:0] IDX_SPEC_IND   = 5'h1B;  // Special indications.
   localparam logic [4:0] IDX_INT_SRC    = 5'h1D;  // Interrupt source.
   localparam logic [4:0] IDX_INT_MASK   = 5'h1E;  // Interrupt mask.
   localparam logic [4:0] IDX_SPEC_CTRL  = 5'h1F;  // Special control.

   // ==========================================================
   // Basic control bit positions.
   localparam int CTL_SOFT_RESET = 15;    // Software reset, self-clearing.
   localparam int CTL_LOOPBACK   = 14;    // Loopback mode.
   localparam int CTL_SPEED_100  = 13;    // Manual speed select.
   localparam int CTL_AN_ENABLE  = 12;    // Autonegotiation enable.
   localparam int CTL_POWER_DOWN = 11;    // General power-down.
   localparam int CTL_AN_RESTART = 9;     // Restart, self-clearing.
   localparam int CTL_DUPLEX     = 8;     // Manual duplex select.
   localparam int CTL_COL_TEST   = 7;     // Collision test.

   // Control reset value without the strap-driven bits.
   localparam logic [15:0] CTL_RESET_VALUE = 16'h0000;
   // Bits that software can write and the register keeps.
   localparam logic [15:0] CTL_WRITE_MASK  = 16'h7980;

   // ==========================================================
   // Basic status bit positions.
   localparam int STS_AN_COMPLETE  = 5;   // Negotiation done.
   localparam int STS_REMOTE_FAULT = 4;   // Latching high.
   localparam int STS_AN_ABILITY   = 3;   // Constant one.
   localparam int STS_LINK_UP      = 2;   // Latching low.
   localparam int STS_JABBER       = 1;   // Latching high.
   localparam int STS_EXT_CAPS     = 0;   // Constant one.

   // Fixed abilities: no T4, all four TX/T modes, AN able, ext caps.
   localparam logic [15:0] STS_FIXED_VALUE = 16'h7809;

   // ==========================================================
   // Timing.
   localparam int CLK_PERIOD_NS      = 10;   // System clock period.
   localparam int SOFT_RESET_TIME_NS = 100;  // Soft reset pulse width.
   localparam int SOFT_RESET_CYCLES  =
      (SOFT_RESET_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STRAP_SYNC_CYCLES  = 3;    // Strap settle before load.

   // ==========================================================
   // Sequencer states, Gray coded along init, run, soft reset.
   typedef enum logic [1:0] {
      PBCS_INIT = 2'b00,                  // Waiting for strap level.
      PBCS_RUN  = 2'b01,                  // Normal operation.
      PBCS_SRST = 2'b11                   // Soft reset in progress.
   } pbcs_state_t;

   // Index decode: true for every mapped register.
   function automatic logic pbcs_index_valid(input logic [4:0] idx);
      pbcs_index_valid = (idx <= IDX_AN_EXP) || (idx == IDX_MODE) ||
                         (idx == IDX_SPEC_MODES) || (idx == IDX_SPEC_IND) ||
                         (idx >= IDX_INT_SRC);
   endfunction : pbcs_index_valid

endpackage : pbcs_pkg

// ### pbcs_latch.sv
// Purpose: One latching status bit, high or low sense.
// Assumes: Live condition comes from logic on the same clock.
// Notes:   The read pulse re-arms the latch to the live level.
module pbcs_latch #(
   parameter bit LATCH_HIGH = 1'b1        // One latches high, zero low.
) (
   input  wire logic clk_i,               // System clock.
   input  wire logic rst_i,               // Asynchronous reset, high.
   input  wire logic clear_i,             // Soft reset re-arm.
   input  wire logic live_i,              // Live condition.
   input  wire logic read_i,              // Status register read.
   output logic      held_o               // Latched value.
);
   import pbcs_pkg::*;

   // ==========================================================
   // Latch update.
   logic next_held;                       // Next latched value.

   // While a read is in progress the live value is taken, so an event in
   // the read cycle still lands in the latch.
   assign next_held = (read_i || clear_i) ? live_i :
                      (LATCH_HIGH ? (held_o | live_i)
                                  : (held_o & live_i));

   // Reset value is the inactive state of the condition.
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         held_o <= ~LATCH_HIGH;
      end else begin
         held_o <= next_held;
      end
   end

endmodule : pbcs_latch

// ### pbcs_regs_properties.sv
// Purpose: Port timing checks for the PHY basic control and status bank.
// Assumes: One clock domain, rst_i asynchronous and active high.
// Notes:   Bound onto pbcs_regs after the module.
module pbcs_regs_properties (
   input wire logic                        clk_i,          // Clock.
   input wire logic                        rst_i,          // Reset.
   input wire logic                        acc_req_i,      // Request.
   input wire logic                        acc_write_i,    // Write.
   input wire logic [pbcs_pkg::IDX_W-1:0]  acc_index_i,    // Index.
   input wire logic [pbcs_pkg::DATA_W-1:0] acc_wdata_i,    // Data in.
   input wire logic                        acc_ready_o,    // Ready.
   input wire logic                        acc_done_o,     // Done.
   input wire logic                        acc_err_o,      // Bad index.
   input wire logic [pbcs_pkg::DATA_W-1:0] acc_rdata_o,    // Data out.
   input wire logic                        an_complete_i,  // AN done.
   input wire logic                        an_speed_100_i, // AN speed.
   input wire logic                        an_full_dup_i,  // AN duplex.
   input wire logic                        soft_reset_o,   // Soft reset.
   input wire logic                        loopback_o,     // Loopback.
   input wire logic                        speed_100_o,    // Speed.
   input wire logic                        full_duplex_o,  // Duplex.
   input wire logic                        an_enable_o,    // AN on.
   input wire logic                        an_restart_o,   // AN pulse.
   input wire logic                        power_down_o    // Power-down.
);
   timeunit 1ns;
   timeprecision 1ps;
   import pbcs_pkg::*;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   // ==========================================================
   // Request decode, kept apart from the design's own helper.
   wire logic take   = acc_req_i && acc_ready_o;  // Accepted request.
   wire logic ctl_wr = take && acc_write_i && (acc_index_i == IDX_CONTROL);
   wire logic sts_rd = take && !acc_write_i && (acc_index_i == IDX_STATUS);
   wire logic bad_ix = (acc_index_i > 5'h06) && (acc_index_i < 5'h1D) &&
                       (acc_index_i != 5'h11) && (acc_index_i != 5'h12) &&
                       (acc_index_i != 5'h1B);    // Unmapped index.
   // ==========================================================
   // Assertions.
   AST_DONE_ONE: assert property (take |=> acc_done_o)
      else $error("No answer one cycle after an accepted request.");
   AST_NO_SPURIOUS: assert property (!take |=> !acc_done_o)
      else $error("Answer without an accepted request.");
   AST_BAD_INDEX: assert property (take |=>
      acc_err_o == $past(bad_ix)) else $error("Index error flag wrong.");
   AST_STATUS_FIXED: assert property (sts_rd |=>
      acc_rdata_o[15:6] == 10'h1E0 && acc_rdata_o[3] && acc_rdata_o[0])
      else $error("Fixed status bits wrong.");
   AST_AN_DONE_BIT: assert property (sts_rd && !power_down_o &&
      !soft_reset_o |=> acc_rdata_o[5] == $past(an_complete_i))
      else $error("Negotiation complete bit wrong.");
   AST_AUTO_MUX: assert property (an_enable_o |->
      speed_100_o == an_speed_100_i && full_duplex_o == an_full_dup_i)
      else $error("Manual speed or duplex used under negotiation.");
   AST_CTL_WRITE: assert property (ctl_wr &&
      !soft_reset_o && !acc_wdata_i[15] |=>
      {loopback_o, an_enable_o, power_down_o} ==
      $past({acc_wdata_i[14], acc_wdata_i[12:11]}))
      else $error("Control write not applied.");
   AST_SRST_START: assert property (ctl_wr && !soft_reset_o &&
      acc_wdata_i[15] |=> soft_reset_o)
      else $error("Soft reset did not start.");
   AST_RESTART_CAUSE: assert property (an_restart_o |->
      $past(ctl_wr && acc_wdata_i[9]) && an_enable_o)
      else $error("Restart pulse without cause or with negotiation off.");
   // Main scenarios reached.
   COV_STATUS: cover property (sts_rd);
   COV_SRST: cover property (ctl_wr && acc_wdata_i[15]);
   COV_ERR: cover property (take ##1 acc_err_o);
endmodule : pbcs_regs_properties

bind pbcs_regs pbcs_regs_properties u_props (
   .clk_i(clk_i), .rst_i(rst_i), .acc_req_i(acc_req_i),
   .acc_write_i(acc_write_i), .acc_index_i(acc_index_i),
   .acc_wdata_i(acc_wdata_i), .acc_ready_o(acc_ready_o),
   .acc_done_o(acc_done_o), .acc_err_o(acc_err_o),
   .acc_rdata_o(acc_rdata_o), .an_complete_i(an_complete_i),
   .an_speed_100_i(an_speed_100_i), .an_full_dup_i(an_full_dup_i),
   .soft_reset_o(soft_reset_o), .loopback_o(loopback_o),
   .speed_100_o(speed_100_o), .full_duplex_o(full_duplex_o),
   .an_enable_o(an_enable_o), .an_restart_o(an_restart_o),
   .power_down_o(power_down_o));

// ### pbcs_mac_model.sv
// Purpose: MAC side indirect access logic driving the bank.
// Assumes: Same clock; requests launched just after a rising edge.
// Notes:   Released qualifiers show inverted values, never stale ones.
module pbcs_mac_model (
   input  wire logic        clk_i,       // Clock.
   output logic             acc_req_o,   // Request.
   output logic             acc_write_o, // Write.
   output logic [4:0]       acc_index_o, // Index.
   output logic [15:0]      acc_wdata_o, // Write data.
   input  wire logic        acc_ready_i, // Ready.
   input  wire logic        acc_done_i,  // Done.
   input  wire logic        acc_err_i,   // Bad index.
   input  wire logic [15:0] acc_rdata_i  // Read data.
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle at time zero.
   initial begin
      acc_req_o = 1'b0;
      acc_write_o = 1'b0;
      acc_index_o = 5'h00;
      acc_wdata_o = 16'h0000;
   end
   // One transfer; the bank is reached only by this path.
   task automatic xfer(input logic w, input logic [4:0] i,
                       input logic [15:0] d, output logic [15:0] rd,
                       output logic er, output logic dn);
      while (acc_ready_i !== 1'b1) @(posedge clk_i);
      acc_req_o <= 1'b1;
      acc_write_o <= w;
      acc_index_o <= i;
      acc_wdata_o <= d;
      @(posedge clk_i);
      // Taken here; release with inverted qualifiers.
      acc_req_o <= 1'b0;
      acc_write_o <= ~w;
      acc_index_o <= ~i;
      acc_wdata_o <= ~d;
      @(posedge clk_i);
      rd = acc_rdata_i;
      er = acc_err_i;
      dn = acc_done_i;
   endtask : xfer
endmodule : pbcs_mac_model

// ### test_pbcs_regs.sv
// Purpose: Self-checking bench for the PHY basic control and status bank.
// Assumes: 100 MHz clock, strap high until the soft reset, short soft reset.
// Notes:   Expected words are worked out here from the bit layout.
module test_pbcs_regs;
   timeunit 1ns;
   timeprecision 1ps;
   import pbcs_pkg::*;
   localparam int          SRST = 2;           // Short soft reset.
   localparam logic [15:0] ID_H = 16'hA5C3;    // Arbitrary value.
   localparam logic [15:0] ID_L = 16'h3C5A;    // Arbitrary value.
   logic        clk_i, rst_i, strap, an_cmp, fault, link, jab, an_spd;
   logic        an_fd, req, wr, rdy, done, err, srst, lpbk, spd, fd;
   logic        ane, anr, pd, colt, er, dn;
   logic [4:0]  idx;
   logic [15:0] wd, rd, rdat;
   int          err_count = 0, compares = 0, srst_len = 0, restarts = 0;
   pbcs_regs #(.ID_HIGH_VALUE(ID_H), .ID_LOW_VALUE(ID_L),
      .SRST_CYCLES(SRST)) dut (.clk_i(clk_i), .rst_i(rst_i),
      .acc_req_i(req), .acc_write_i(wr), .acc_index_i(idx),
      .acc_wdata_i(wd), .acc_ready_o(rdy), .acc_done_o(done),
      .acc_err_o(err), .acc_rdata_o(rdat), .speed_strap_i(strap),
      .an_complete_i(an_cmp), .remote_fault_i(fault), .link_up_i(link),
      .jabber_i(jab), .an_speed_100_i(an_spd), .an_full_dup_i(an_fd),
      .soft_reset_o(srst), .loopback_o(lpbk), .speed_100_o(spd),
      .full_duplex_o(fd), .an_enable_o(ane), .an_restart_o(anr),
      .power_down_o(pd), .col_test_o(colt));
   pbcs_mac_model u_mac (.clk_i(clk_i), .acc_req_o(req),
      .acc_write_o(wr), .acc_index_o(idx), .acc_wdata_o(wd),
      .acc_ready_i(rdy), .acc_done_i(done), .acc_err_i(err),
      .acc_rdata_i(rdat));
   // Clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Pulse and level counters on outputs that stand only briefly.
   always @(posedge clk_i) begin
      if (srst === 1'b1) srst_len++;
      if (anr === 1'b1) restarts++;
   end
   // Compare one word and count it.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   // One access; every accepted request must be answered.
   task automatic acc(input logic w, input logic [4:0] i,
                      input logic [15:0] d);
      u_mac.xfer(w, i, d, rd, er, dn);
      chk({14'h0000, rdy, dn}, 16'h0003);
   endtask : acc
   // Verdict and end of run.
   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test
   // Main sequence.
   initial begin
      {rst_i, strap, link, an_fd, an_cmp, fault, jab, an_spd} = 8'hF0;
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      acc(1'b0, IDX_CONTROL, 16'h0000);
      chk(rd, 16'h3000);
      chk({13'h0000, ane, spd, fd}, 16'h0005);
      an_spd <= 1'b1;
      an_fd <= 1'b0;
      acc(1'b1, IDX_CONTROL, 16'h4980);
      acc(1'b0, IDX_CONTROL, 16'h0000);
      chk(rd, 16'h4980);
      chk(16'({lpbk, pd, colt, spd, fd}), 16'h001D);
      acc(1'b1, IDX_CONTROL, 16'h1000);
      acc(1'b1, IDX_CONTROL, 16'h1200);
      acc(1'b0, IDX_CONTROL, 16'h0000);
      chk(rd, 16'h1000);
      chk(restarts[15:0], 16'h0001);
      chk({14'h0000, ane, spd}, 16'h0003);
      an_cmp <= 1'b1;
      acc(1'b0, IDX_STATUS, 16'h0000);
      acc(1'b0, IDX_STATUS, 16'h0000);
      chk(rd, 16'h782D);
      {fault, jab, link} <= 3'b110;
      @(posedge clk_i);
      {fault, jab, link} <= 3'b001;
      acc(1'b0, IDX_STATUS, 16'h0000);
      chk(rd, 16'h783B);
      acc(1'b0, IDX_STATUS, 16'h0000);
      chk(rd, 16'h782D);
      srst_len = 0;
      strap <= 1'b0;
      acc(1'b1, IDX_CONTROL, 16'h8000);
      repeat (SRST + 2) @(posedge clk_i);
      chk(srst_len[15:0], 16'(SRST));
      acc(1'b0, IDX_CONTROL, 16'h0000);
      chk(rd, 16'h0000);
      acc(1'b1, IDX_AN_ADV, 16'hFFFF);
      acc(1'b0, IDX_AN_ADV, 16'h0000);
      chk(rd, 16'h0000);
      for (int i = 0; i < 32; i++) begin
         acc(1'b0, 5'(i), 16'h0000);
         chk({15'h0000, er}, {15'h0000, (i > 6 && i < 29 && i != 17 &&
            i != 18 && i != 27)});
         if (i > 1) chk(rd, (i == 2) ? ID_H :
            (i == 3) ? ID_L : 16'h0000);
      end
      end_of_test;
   end
   // Watchdog well beyond the roughly 120 cycles the tests need.
   initial begin
      #20000;
      err_count++;
      end_of_test;
   end
endmodule : test_pbcs_regs
